// file: dv/board_model.sv
`timescale 1ns/1ns
`default_nettype none
module board_model (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic oe_n_i,
    input wire logic pu_i,
    input wire logic pd_i,
    input wire logic ext_pu_i,
    output logic line_o
);
    logic last_r = 1'b0;
    always_ff @(posedge clk_i)
    begin
        if (!oe_n_i)
            last_r <= pin_i;
    end
    // an unpulled floating line shows the inverse so stale levels never pass
    assign line_o = !oe_n_i ? pin_i : (pu_i || ext_pu_i) ? 1'b1
        : pd_i ? 1'b0 : ~last_r;
endmodule
`default_nettype wire

// file: dv/status_pin_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_params.svh"
module status_pin_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic pll_lock_i,
    input wire logic status_pin_o,
    input wire logic status_pin_oe_n_o,
    input wire logic status_pin_pullup_en_o,
    input wire logic [1:0] push_pull_strength_o,
    input wire logic serial_data_pullup_en_o,
    input wire logic serial_clock_pullup_en_o,
    input wire logic clock_outputs_en_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence hi_wr;
        reg_wr_i && reg_addr_i == `OFF_STATUS_CFG_HI;
    endsequence
    sequence misc_wr;
        reg_wr_i && reg_addr_i == `OFF_MISC_IO_CFG;
    endsequence
    // a gap cycle keeps a stray write from slipping between the two steps
    sequence pol_then_sel(logic [7:0] c, logic [4:0] s);
        hi_wr ##0 reg_wdata_i == c ##1 !reg_wr_i ##1
            reg_wr_i && reg_addr_i == `OFF_STATUS_CFG_LO && reg_wdata_i[4:0] == s;
    endsequence
    AST_HIZ: assert property (hi_wr ##0 reg_wdata_i[3] |-> ##2 status_pin_oe_n_o)
        else $error("tristate did not float the pin");
    AST_PU: assert property (hi_wr |-> ##2 status_pin_pullup_en_o == $past(reg_wdata_i[1], 2))
        else $error("pull-up enable wrong");
    AST_PP: assert property (misc_wr |-> ##2 push_pull_strength_o == $past(reg_wdata_i[5:4], 2))
        else $error("push-pull strength wrong");
    AST_SER: assert property (misc_wr |-> ##2
        {serial_data_pullup_en_o, serial_clock_pullup_en_o} == $past(reg_wdata_i[1:0], 2))
        else $error("serial pull-ups wrong");
    AST_OD: assert property (hi_wr ##0 reg_wdata_i[4:3] == 2'b10 |->
        ##2 (status_pin_oe_n_o || !status_pin_o))
        else $error("open drain drove high");
    AST_RAW: assert property (reg_wr_i && reg_addr_i == `OFF_STATUS_CFG_LO &&
        reg_wdata_i[4:0] == `SEL_RAW |-> ##2 (status_pin_oe_n_o || !status_pin_o))
        else $error("raw selector drove high");
    AST_HIGH: assert property (pol_then_sel(8'h02, `SEL_CONST_HIGH) |->
        ##2 status_pin_o && !status_pin_oe_n_o)
        else $error("constant high wrong");
    AST_INV: assert property (pol_then_sel(8'h03, `SEL_CONST_LOW) |->
        ##2 status_pin_o && !status_pin_oe_n_o)
        else $error("inverted constant low wrong");
    AST_CLKEN: assert property ($rose(clock_outputs_en_o) |-> $past(pll_lock_i) ||
        $past(pll_lock_i, 2) || $past(reg_wr_i && reg_addr_i == `OFF_MISC_IO_CFG, 2))
        else $error("clock outputs enabled without lock");
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [6:0] src = 7'h00;
    logic ext_pu = 1'b0;
    logic [7:0] reg_rdata_o;
    logic status_pin_i, status_pin_o, status_pin_oe_n_o, status_pin_pullup_en_o;
    logic status_pin_pulldown_en_o, serial_data_pullup_en_o, serial_clock_pullup_en_o;
    logic clock_outputs_en_o;
    logic [1:0] status_pin_strength_o, push_pull_strength_o;
    int n_fail = 0;
    int n_tests = 0;
    always #20 clk_i = ~clk_i;
    status_pin_io dut_u (.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
        .pll_lock_i(src[0]), .ref0_los_i(src[1]), .xtal_los_i(src[2]), .ref0_act_i(src[3]),
        .ref0_invalid_i(src[4]), .int_status_i(8'h0f), .int_enable_i(src[5] ? 8'h08 : 8'hf0),
        .startup_done_i(src[6]), .status_pin_i, .serial_data_pin_i(1'b1),
        .serial_clock_pin_i(1'b0), .enable_select_pin_i(1'b1), .die_bond_option_i(1'b1),
        .status_pin_o, .status_pin_oe_n_o, .status_pin_pullup_en_o, .status_pin_pulldown_en_o,
        .status_pin_strength_o, .push_pull_strength_o, .serial_data_pullup_en_o,
        .serial_clock_pullup_en_o, .clock_outputs_en_o);
    board_model bm_u (.clk_i, .pin_i(status_pin_o), .oe_n_i(status_pin_oe_n_o),
        .pu_i(status_pin_pullup_en_o), .pd_i(status_pin_pulldown_en_o), .ext_pu_i(ext_pu),
        .line_o(status_pin_i));
    function automatic logic [7:0] pad();
        return {1'b0, status_pin_oe_n_o, status_pin_o, status_pin_i, status_pin_pullup_en_o,
            status_pin_pulldown_en_o, status_pin_strength_o};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        n_tests++;
        if ((got & m) !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got & m, exp);
        end
    endtask
    // leaves a quiet cycle so the strobe is never set twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        reg_addr_i = a;
        @(negedge clk_i);
        chk(reg_rdata_o, exp, m);
    endtask
    task automatic t_reset();
        rd(4'h0, 8'h2f, 8'hff);
        rd(4'h2, 8'h02, 8'hff);
        rd(4'h3, 8'h8a, 8'hfe);
        chk(pad(), 8'h0a, 8'hff);
        wr(4'h3, 8'h00);
        wr(4'h9, 8'h00);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h1f, 8'hff);
        rd(4'h3, 8'h8a, 8'hfe);
        wr(4'h1, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_boot();
        repeat (4) @(negedge clk_i);
        chk({7'h0, clock_outputs_en_o}, 8'h00, 8'hff);
        src[0] = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({7'h0, clock_outputs_en_o}, 8'h01, 8'hff);
        src[0] = 1'b0;
        repeat (4) @(negedge clk_i);
        chk({7'h0, clock_outputs_en_o}, 8'h01, 8'hff);
        // a mid-run reset drops the enable and refills the startup latch
        arst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({7'h0, clock_outputs_en_o}, 8'h00, 8'hff);
        arst_n_i = 1'b1;
        wr(4'h0, 8'h6f);
        src[0] = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({7'h0, clock_outputs_en_o}, 8'h00, 8'hff);
        rd(4'h3, 8'h8a, 8'hfe);
        src[0] = 1'b0;
        wr(4'h0, 8'haf);
        chk({7'h0, clock_outputs_en_o}, 8'h01, 8'hff);
        wr(4'h0, 8'h2f);
        $display("t_boot done");
    endtask
    task automatic t_sel();
        logic [4:0] sel_t [11] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h1d,
            5'h1e, 5'h03, 5'h1f};
        logic [3:0] const_t = 4'b0010;
        logic v;
        for (int i = 0; i < 11; i++)
            for (int k = 0; k < 2; k++)
                for (int p = 0; p < 2; p++)
                begin
                    src = (i < 7) ? 7'(7'h01 << i) ^ {7{k[0]}} : {7{k[0]}};
                    v = ((i < 7) ? !k[0] : const_t[i - 7]) ^ (p[0] && i != 10);
                    wr(4'h2, {7'h01, p[0]});
                    wr(4'h1, {3'h0, sel_t[i]});
                    chk(pad(), {1'b0, 1'b0, v, 5'h0}, 8'h60);
                    rd(4'h4, {6'h0, v && sel_t[i] <= 5'h04, 1'b0}, 8'h02);
                end
        $display("t_sel done");
    endtask
    task automatic t_pad();
        wr(4'h1, 8'h1e);
        wr(4'h2, 8'h12);
        chk(pad(), 8'h5b, 8'hdf);
        wr(4'h2, 8'h13);
        chk(pad(), 8'h0b, 8'hff);
        wr(4'h2, 8'h1b);
        chk(pad(), 8'h58, 8'hdc);
        wr(4'h2, 8'h0a);
        chk(pad(), 8'h58, 8'hdc);
        wr(4'h2, 8'h04);
        chk(pad(), 8'h36, 8'hff);
        wr(4'h2, 8'h08);
        ext_pu = 1'b1;
        @(negedge clk_i);
        chk(pad(), 8'h50, 8'hdc);
        wr(4'h0, 8'h9e);
        wr(4'h2, 8'h02);
        chk(pad(), 8'h39, 8'hff);
        chk({4'h0, push_pull_strength_o, serial_data_pullup_en_o, serial_clock_pullup_en_o},
            8'h06, 8'hff);
        rd(4'h0, 8'h9e, 8'hff);
        $display("t_pad done");
    endtask
    task automatic test_done();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge clk_i);
        arst_n_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_boot();
        t_sel();
        t_pad();
        test_done();
    end
    initial
    begin
        #200000;
        n_fail++;
        test_done();
    end
endmodule
bind status_pin_io status_pin_properties chk_u (.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .pll_lock_i, .status_pin_o, .status_pin_oe_n_o, .status_pin_pullup_en_o,
    .push_pull_strength_o, .serial_data_pullup_en_o, .serial_clock_pullup_en_o,
    .clock_outputs_en_o);
`default_nettype wire

// file: hdl/status_pin_io.sv
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_params.svh"
module status_pin_io
    import status_pin_pkg::*;
#(
    parameter int INT_W = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // internal status sources, same clock
    input wire logic pll_lock_i,
    input wire logic ref0_los_i,
    input wire logic xtal_los_i,
    input wire logic ref0_act_i,
    input wire logic ref0_invalid_i,
    input wire logic [INT_W-1:0] int_status_i,
    input wire logic [INT_W-1:0] int_enable_i,
    input wire logic startup_done_i,
    // pads, asynchronous
    input wire logic status_pin_i,
    input wire logic serial_data_pin_i,
    input wire logic serial_clock_pin_i,
    input wire logic enable_select_pin_i,
    input wire logic die_bond_option_i,
    // status pad drive and other io controls
    output logic status_pin_o,
    output logic status_pin_oe_n_o,
    output logic status_pin_pullup_en_o,
    output logic status_pin_pulldown_en_o,
    output logic [1:0] status_pin_strength_o,
    output logic [1:0] push_pull_strength_o,
    output logic serial_data_pullup_en_o,
    output logic serial_clock_pullup_en_o,
    output logic clock_outputs_en_o
);
    logic [7:0] misc_io_r, misc_io_nxt;
    logic [15:0] status_cfg_r, status_cfg_nxt;
    logic [`BOOT_W-1:0] boot_pins_r, boot_pins_nxt;
    logic [1:0] settle_r, settle_nxt;
    logic bond_r, bond_nxt;
    boot_state_type boot_r, boot_nxt;
    logic pin_o_r, pin_o_nxt;
    logic oe_n_r, oe_n_nxt;
    logic pu_r, pd_r;
    logic [1:0] strength_r, strength_nxt;
    logic [1:0] pp_r;
    logic serial_data_pullup_en_r, serial_clock_pullup_en_r;
    logic clk_en_r, clk_en_nxt;
    logic readback_r, readback_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    logic [3:0] pads_sync;
    logic bond_sync;
    logic src_value, readback_ok, driven, dev_int;
    logic [4:0] sel;

    // pads are asynchronous; two stages before any logic sees them
    sync2 #(.WIDTH(5)) u_pad_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({die_bond_option_i, enable_select_pin_i, serial_clock_pin_i,
              serial_data_pin_i, status_pin_i}),
        .q_o({bond_sync, pads_sync})
    );

    assign sel = status_cfg_r[`ST_SEL_HI:`ST_SEL_LO];
    // interrupt sources already run on this clock, so no synchroniser here
    assign dev_int = |(int_status_i & int_enable_i);

    status_source_mux u_mux (
        .sel_i(sel),
        .pll_lock_i(pll_lock_i),
        .ref0_los_i(ref0_los_i),
        .xtal_los_i(xtal_los_i),
        .ref0_act_i(ref0_act_i),
        .ref0_invalid_i(ref0_invalid_i),
        .dev_int_i(dev_int),
        .dev_ready_i(startup_done_i),
        .value_o(src_value),
        .readback_ok_o(readback_ok)
    );

    // register writes
    always_comb
    begin
        misc_io_nxt = misc_io_r;
        status_cfg_nxt = status_cfg_r;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `OFF_MISC_IO_CFG: misc_io_nxt = reg_wdata_i;
                // the two halves of the status configuration are written independently
                `OFF_STATUS_CFG_LO:
                begin
                    status_cfg_nxt[7:0] = reg_wdata_i;
                end
                `OFF_STATUS_CFG_HI:
                begin
                    status_cfg_nxt[15:8] = reg_wdata_i;
                end
                default: ;
            endcase
        end
        // reserved bits stay zero
        status_cfg_nxt = status_cfg_nxt & `STATUS_CFG_RW_MASK;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            misc_io_r <= `MISC_IO_RESET;
            status_cfg_r <= `STATUS_CFG_RESET;
        end
        else
        begin
            misc_io_r <= misc_io_nxt;
            status_cfg_r <= status_cfg_nxt;
        end
    end

    // startup capture: pin levels are taken once the synchronisers are filled
    always_comb
    begin
        boot_nxt = boot_r;
        boot_pins_nxt = boot_pins_r;
        bond_nxt = bond_r;
        settle_nxt = settle_r;
        case (boot_r)
            // the second synchroniser stage holds pad levels only from the second
            // edge on; capturing earlier would latch the reset zeros
            boot_wait:
            begin
                settle_nxt = settle_r + 2'h1;
                if (settle_nxt == `BOOT_SETTLE)
                    boot_nxt = boot_capture;
            end
            boot_capture:
            begin
                boot_pins_nxt = '0;
                boot_pins_nxt[`BOOT_STATUS] = pads_sync[0];
                boot_pins_nxt[`BOOT_SDATA] = pads_sync[1];
                boot_pins_nxt[`BOOT_SCLK] = pads_sync[2];
                boot_pins_nxt[`BOOT_ENSEL] = pads_sync[3];
                boot_nxt = boot_done;
            end
            // the pin latch then holds until the next reset; the bond bit keeps following its synchronised pad
            boot_done: boot_nxt = boot_done;
            default: boot_nxt = boot_wait;
        endcase
        bond_nxt = bond_sync;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            boot_r <= boot_wait;
            boot_pins_r <= '0;
            bond_r <= 1'b0;
            settle_r <= 2'h0;
        end
        else
        begin
            boot_r <= boot_nxt;
            boot_pins_r <= boot_pins_nxt;
            bond_r <= bond_nxt;
            settle_r <= settle_nxt;
        end
    end

    // status pad drive
    always_comb
    begin
        logic pol;
        pol = status_cfg_r[`ST_POL];
        if (sel == `SEL_RAW)
        begin
            driven = src_value;
        end
        else
        begin
            driven = src_value ^ pol;
        end
        pin_o_nxt = driven;
        oe_n_nxt = 1'b0;
        strength_nxt = misc_io_r[`IO_PP_HI:`IO_PP_LO];
        if (status_cfg_r[`ST_OD])
        begin
            // driven folds polarity for every selector but raw: 0 pulls low, 1 releases
            pin_o_nxt = 1'b0;
            oe_n_nxt = driven;
            strength_nxt = misc_io_r[`IO_OD_HI:`IO_OD_LO];
        end
        if (status_cfg_r[`ST_HIZ])
        begin
            pin_o_nxt = 1'b0;
            oe_n_nxt = 1'b1;
        end
        // readback reports the intended level for selectors up to SEL_XTAL_LOS, zero otherwise, so a pull-up cannot mask it
        readback_nxt = readback_ok ? driven : 1'b0;
        // under code 0 gating is released only by lock; code 2 ignores lock
        case (misc_io_r[`IO_STARTUP_HI:`IO_STARTUP_LO])
            `STARTUP_WAIT_LOCK: clk_en_nxt = clk_en_r | pll_lock_i;
            `STARTUP_NO_WAIT: clk_en_nxt = 1'b1;
            // reserved codes freeze the enable rather than guess a meaning
            default: clk_en_nxt = clk_en_r;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_o_r <= 1'b0;
            oe_n_r <= 1'b1;
            pu_r <= 1'b1;
            pd_r <= 1'b0;
            strength_r <= `PUSH_PULL_STRENGTH_RESET;
            pp_r <= `PUSH_PULL_STRENGTH_RESET;
            serial_data_pullup_en_r <= 1'b1;
            serial_clock_pullup_en_r <= 1'b1;
            clk_en_r <= 1'b0;
            readback_r <= 1'b0;
        end
        else
        begin
            pin_o_r <= pin_o_nxt;
            oe_n_r <= oe_n_nxt;
            pu_r <= status_cfg_r[`ST_PU];
            // pull-down with open-drain is left to software to avoid
            pd_r <= status_cfg_r[`ST_PD];
            strength_r <= strength_nxt;
            pp_r <= misc_io_r[`IO_PP_HI:`IO_PP_LO];
            serial_data_pullup_en_r <= misc_io_r[`IO_SERIAL_DATA_PULLUP_EN];
            serial_clock_pullup_en_r <= misc_io_r[`IO_SERIAL_CLOCK_PULLUP_EN];
            clk_en_r <= clk_en_nxt;
            readback_r <= readback_nxt;
        end
    end

    // registered read data; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr_i)
            `OFF_MISC_IO_CFG: rdata_nxt = misc_io_r;
            `OFF_STATUS_CFG_LO: rdata_nxt = status_cfg_r[7:0];
            `OFF_STATUS_CFG_HI: rdata_nxt = status_cfg_r[15:8];
            `OFF_STARTUP_STS: rdata_nxt = {bond_r, 1'b0, boot_pins_r};
            `OFF_PIN_READBACK: rdata_nxt = {6'h00, readback_r, 1'b0};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // every output is a flop so pad timing does not depend on the muxes
    assign reg_rdata_o = rdata_r;
    assign status_pin_o = pin_o_r;
    assign status_pin_oe_n_o = oe_n_r;
    assign status_pin_pullup_en_o = pu_r;
    assign status_pin_pulldown_en_o = pd_r;
    assign status_pin_strength_o = strength_r;
    assign push_pull_strength_o = pp_r;
    assign serial_data_pullup_en_o = serial_data_pullup_en_r;
    assign serial_clock_pullup_en_o = serial_clock_pullup_en_r;
    assign clock_outputs_en_o = clk_en_r;
endmodule
`default_nettype wire

// file: hdl/status_pin_params.svh
`ifndef STATUS_PIN_PARAMS_SVH
`define STATUS_PIN_PARAMS_SVH

// register offsets within the pin block window (no offsets printed; chosen locally)
`define ADDR_W 4
`define OFF_MISC_IO_CFG 4'h0
`define OFF_STATUS_CFG_LO 4'h1
`define OFF_STATUS_CFG_HI 4'h2
`define OFF_STARTUP_STS 4'h3
`define OFF_PIN_READBACK 4'h4

// misc io configuration fields
`define IO_STARTUP_HI 7
`define IO_STARTUP_LO 6
`define IO_PP_HI 5
`define IO_PP_LO 4
`define IO_OD_HI 3
`define IO_OD_LO 2
`define IO_SERIAL_DATA_PULLUP_EN 1
`define IO_SERIAL_CLOCK_PULLUP_EN 0
`define MISC_IO_RESET 8'h2f

// status pin configuration fields
`define ST_OD 12
`define ST_HIZ 11
`define ST_PD 10
`define ST_PU 9
`define ST_POL 8
`define ST_SEL_HI 4
`define ST_SEL_LO 0
`define STATUS_CFG_RESET 16'h0200
`define STATUS_CFG_RW_MASK 16'h1f1f

// startup output gating codes
`define STARTUP_WAIT_LOCK 2'h0
`define STARTUP_NO_WAIT 2'h2

// status source selector codes
`define SEL_PLL_LOCK 5'h00
`define SEL_REF0_LOS 5'h02
`define SEL_XTAL_LOS 5'h04
`define SEL_REF0_ACT 5'h05
`define SEL_REF0_INV 5'h07
`define SEL_DEV_INT 5'h09
`define SEL_DEV_READY 5'h0a
`define SEL_CONST_LOW 5'h1d
`define SEL_CONST_HIGH 5'h1e
`define SEL_RAW 5'h1f

// startup latch layout
`define BOOT_W 6
`define BOOT_STATUS 0
`define BOOT_SDATA 1
`define BOOT_SCLK 2
`define BOOT_ENSEL 3
`define STS_BOND 7

// edges after reset release before the startup latch may sample the pads
`define BOOT_SETTLE 2'h2
// push-pull strength out of reset, matching the misc io default
`define PUSH_PULL_STRENGTH_RESET 2'h2

`endif

// file: hdl/status_pin_pkg.sv
package status_pin_pkg;
    typedef enum logic [1:0] {
        boot_wait,
        boot_capture,
        boot_done
    } boot_state_type;
endpackage

// file: hdl/status_source_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_params.svh"
module status_source_mux (
    input wire logic [4:0] sel_i,
    input wire logic pll_lock_i,
    input wire logic ref0_los_i,
    input wire logic xtal_los_i,
    input wire logic ref0_act_i,
    input wire logic ref0_invalid_i,
    input wire logic dev_int_i,
    input wire logic dev_ready_i,
    output logic value_o,
    output logic readback_ok_o
);
    always_comb
    begin
        value_o = 1'b0;
        case (sel_i)
            `SEL_PLL_LOCK: value_o = pll_lock_i;
            `SEL_REF0_LOS: value_o = ref0_los_i;
            `SEL_XTAL_LOS: value_o = xtal_los_i;
            `SEL_REF0_ACT: value_o = ref0_act_i;
            `SEL_REF0_INV: value_o = ref0_invalid_i;
            `SEL_DEV_INT: value_o = dev_int_i;
            `SEL_DEV_READY: value_o = dev_ready_i;
            `SEL_CONST_LOW: value_o = 1'b0;
            `SEL_CONST_HIGH: value_o = 1'b1;
            // reserved codes drive low
            default: value_o = 1'b0;
        endcase
    end
    assign readback_ok_o = (sel_i <= `SEL_XTAL_LOS);
endmodule
`default_nettype wire

// file: hdl/sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule
`default_nettype wire
